// File: ccs_pkg.sv
// Constants and carrier types for the processor control-state block.
// Assumes a single processor clock; the execution pipeline outside drives the event and operand ports.
package ccs_pkg;

  // ----------------------------------------
  // Status word layout
  // ----------------------------------------
  localparam int SW_COND = 0;
  localparam int SW_CLIP = 1;
  localparam int SW_MASK_LO = 4;
  localparam int SW_MASK_HI = 7;
  localparam int SW_DVD_SIGN = 8;
  localparam int SW_DVS_SIGN = 9;
  localparam int SW_CACHE_LOCK = 12;
  localparam int SW_MUTE = 28;
  localparam int SW_BANK = 29;
  localparam int SW_PRIV = 30;
  // Bits that exist; everything else is reserved and reads zero
  localparam logic [31:0] SW_IMPL_MASK = 32'h700013f3;
  localparam logic [31:0] SW_USER_MASK = 32'h00000303;
  localparam logic [31:0] SW_RESET = 32'h700000f0;
  localparam logic [31:0] VBP_RESET = 32'h00000000;
  localparam logic [31:0] PC_RESET = 32'ha0000000;
  localparam logic [31:0] PC_AHEAD = 32'h00000004;
  localparam logic [31:0] INSN_STEP = 32'h00000002;

  // ----------------------------------------
  // Register selectors and operations
  // ----------------------------------------
  typedef enum logic [2:0] {CCS_R_SW, CCS_R_SSW, CCS_R_SPC, CCS_R_GBP, CCS_R_VBP, CCS_R_NONE} ccs_reg_e;
  typedef enum logic [1:0] {CCS_SZ_BYTE, CCS_SZ_WORD, CCS_SZ_LONG} ccs_size_e;
  typedef enum logic [1:0] {CCS_LIT_MOVE, CCS_LIT_ADD, CCS_LIT_CMPEQ, CCS_LIT_LOGIC} ccs_lit_e;
  typedef enum logic [1:0] {CCS_BR_NONE, CCS_BR_DELAYED, CCS_BR_NORMAL} ccs_br_e;

  typedef struct packed {
    logic valid;
    logic write;
    ccs_reg_e sel;
    logic [31:0] wdata;
  } ccs_creg_s;

  typedef struct packed {
    logic cond_we;
    logic cond_val;
    logic dvd_we;
    logic dvd_val;
    logic dvs_we;
    logic dvs_val;
  } ccs_flag_s;

  typedef struct packed {
    logic valid;
    ccs_size_e size;
    logic [31:0] addr;
    logic [31:0] rdata;
  } ccs_mem_s;

endpackage

// File: ccs_core_state.sv
// Control-state registers, operand formatting and program counter sequencing of the core.
// Assumes the decode stage presents one instruction's effects per clock and the memory system a raw bus word.
module ccs_core_state
  import ccs_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_endian_select_pin,
  input wire ccs_creg_s i_creg,
  input wire ccs_flag_s i_flags,
  input wire logic i_exception,
  input wire logic i_return,
  input wire logic i_advance,
  input wire ccs_br_e i_branch,
  input wire logic i_branch_taken,
  input wire logic [31:0] i_branch_target,
  input wire ccs_mem_s i_mem,
  input wire logic [7:0] i_literal,
  input wire ccs_lit_e i_lit_kind,
  input wire logic [31:0] i_bit_operand,
  input wire logic [31:0] i_bit_mask,
  input wire logic [1:0] i_bit_op,
  output logic [31:0] o_creg_rdata,
  output logic o_priv_fault,
  output logic [31:0] o_pc,
  output logic [31:0] o_pc_read,
  output logic [31:0] o_load_data,
  output logic o_address_error,
  output logic [31:0] o_literal,
  output logic [31:0] o_bit_result,
  output logic o_little_endian,
  output logic [3:0] o_interrupt_mask_level,
  output logic o_cond,
  output logic o_clip,
  output logic o_privilege_level_bit,
  output logic o_bank_select_bit,
  output logic o_exception_mute_bit,
  output logic [31:0] o_global_base_pointer,
  output logic [31:0] o_vector_base_pointer
);

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  // Assertion is asynchronous so reset works without a clock; release is retimed to the clock
  logic rst_meta_b;
  logic rst_b;

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rst_meta_b <= 1'b0;
      rst_b <= 1'b0;
    end
    else
    begin
      rst_meta_b <= 1'b1;
      rst_b <= rst_meta_b;
    end
  end

  // ----------------------------------------
  // Endian strap
  // ----------------------------------------
  // Pin is synchronised and captured only while reset is held, so the order cannot change until the next reset.
  // The synchroniser itself takes no reset: it must follow the strap while reset is asserted,
  // otherwise the capture below would only ever see its reset value.
  logic endian_meta;
  logic endian_sync;
  logic little_endian;

  always_ff @(posedge i_clk)
  begin
    endian_meta <= i_endian_select_pin;
    endian_sync <= endian_meta;
  end

  always_ff @(posedge i_clk)
  begin
    if (!rst_b)
      little_endian <= endian_sync;
  end

  // ----------------------------------------
  // Control register access decode
  // ----------------------------------------
  logic [31:0] processor_status_word;
  logic [31:0] saved_status_word;
  logic [31:0] saved_program_counter;
  logic [31:0] global_base_pointer;
  logic [31:0] vector_base_pointer;
  logic [31:0] pc;

  wire priv = processor_status_word[SW_PRIV];
  wire creg_wr = i_creg.valid && i_creg.write;
  // Global base is the only control register open to user mode
  wire creg_allowed = priv || (i_creg.sel == CCS_R_GBP);
  wire creg_fault = i_creg.valid && !creg_allowed && (i_creg.sel != CCS_R_NONE);
  wire wr_ok = creg_wr && creg_allowed && !i_exception;
  wire wr_sw = wr_ok && (i_creg.sel == CCS_R_SW);
  wire wr_ssw = wr_ok && (i_creg.sel == CCS_R_SSW);
  wire wr_spc = wr_ok && (i_creg.sel == CCS_R_SPC);
  wire wr_gbp = wr_ok && (i_creg.sel == CCS_R_GBP);
  wire wr_vbp = wr_ok && (i_creg.sel == CCS_R_VBP);

  // ----------------------------------------
  // Status word next value
  // ----------------------------------------
  logic [31:0] next_sw;
  logic [31:0] sw_flags;

  // Dedicated flag instructions work at any privilege; plain operations assert no write enable
  always_comb
  begin
    sw_flags = processor_status_word;
    if (i_flags.cond_we)
      sw_flags[SW_COND] = i_flags.cond_val;
    if (i_flags.dvd_we)
      sw_flags[SW_DVD_SIGN] = i_flags.dvd_val;
    if (i_flags.dvs_we)
      sw_flags[SW_DVS_SIGN] = i_flags.dvs_val;
  end

  // Exception outranks a status write, which outranks a return from exception
  always_comb
  begin
    next_sw = sw_flags;
    if (i_exception)
    begin
      // Mask level is kept as is when an interrupt is taken
      next_sw[SW_PRIV] = 1'b1;
      next_sw[SW_BANK] = 1'b1;
      next_sw[SW_MUTE] = 1'b1;
    end
    else if (wr_sw)
      next_sw = i_creg.wdata & SW_IMPL_MASK;
    else if (i_return)
      next_sw = saved_status_word & SW_IMPL_MASK;
  end

  // Flags of the user group have no defined reset value, held at zero here for determinism
  always_ff @(posedge i_clk or negedge rst_b)
  begin
    if (!rst_b)
      processor_status_word <= SW_RESET;
    else
      processor_status_word <= next_sw;
  end

  // ----------------------------------------
  // Saved state and base registers
  // ----------------------------------------
  // Saved copies and global base take no reset: their contents are undefined until written
  always_ff @(posedge i_clk)
  begin
    if (i_exception)
    begin
      saved_status_word <= processor_status_word;
      saved_program_counter <= pc;
    end
    else
    begin
      if (wr_ssw)
        saved_status_word <= i_creg.wdata;
      if (wr_spc)
        saved_program_counter <= i_creg.wdata;
    end
    if (wr_gbp)
      global_base_pointer <= i_creg.wdata;
  end

  always_ff @(posedge i_clk or negedge rst_b)
  begin
    if (!rst_b)
      vector_base_pointer <= VBP_RESET;
    else if (wr_vbp)
      vector_base_pointer <= i_creg.wdata;
  end

  // ----------------------------------------
  // Program counter and delayed branching
  // ----------------------------------------
  logic slot_pending;
  logic [31:0] slot_target;
  logic [31:0] next_pc;

  wire br_delayed = i_advance && i_branch_taken && (i_branch == CCS_BR_DELAYED);
  wire br_normal = i_advance && i_branch_taken && (i_branch == CCS_BR_NORMAL);
  wire [31:0] pc_seq = pc + INSN_STEP;

  // A pending slot target is taken only when the slot instruction itself retires
  always_comb
  begin
    next_pc = pc;
    if (i_exception)
      next_pc = vector_base_pointer;
    else if (i_return)
      next_pc = saved_program_counter;
    else if (i_advance && slot_pending)
      next_pc = slot_target;
    else if (br_normal)
      next_pc = i_branch_target;
    else if (i_advance)
      next_pc = pc_seq;
  end

  always_ff @(posedge i_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pc <= PC_RESET;
      slot_pending <= 1'b0;
      slot_target <= PC_RESET;
    end
    else
    begin
      pc <= next_pc;
      if (i_exception || i_return)
        slot_pending <= 1'b0;
      else if (br_delayed && !slot_pending)
      begin
        // Slot instruction executes first, then control moves to the target
        slot_pending <= 1'b1;
        slot_target <= i_branch_target;
      end
      else if (i_advance)
        slot_pending <= 1'b0;
    end
  end

  // ----------------------------------------
  // Operand formatting
  // ----------------------------------------
  logic [31:0] lane_word;
  logic [7:0] load_byte;
  logic [15:0] load_half;
  logic [31:0] next_load;
  logic misaligned;
  logic [31:0] swapped_word;
  logic [1:0] lane_sel;

  // The memory puts the byte of address 4n+k on lane k of the bus word.
  // Big-endian reverses the lanes so that the lowest address is the most significant byte,
  // and the lane index flips with it so byte, word and longword picks all agree.
  assign swapped_word = {i_mem.rdata[7:0], i_mem.rdata[15:8], i_mem.rdata[23:16], i_mem.rdata[31:24]};
  assign lane_word = little_endian ? i_mem.rdata : swapped_word;
  assign lane_sel = little_endian ? i_mem.addr[1:0] : ~i_mem.addr[1:0];
  assign load_byte = lane_word[8*lane_sel +: 8];
  assign load_half = lane_sel[1] ? lane_word[31:16] : lane_word[15:0];
  assign misaligned = ((i_mem.size == CCS_SZ_WORD) && i_mem.addr[0]) ||
    ((i_mem.size == CCS_SZ_LONG) && (i_mem.addr[1:0] != 2'b00));

  always_comb
  begin
    unique case (i_mem.size)
      CCS_SZ_BYTE: next_load = {{24{load_byte[7]}}, load_byte};
      CCS_SZ_WORD: next_load = {{16{load_half[15]}}, load_half};
      default: next_load = lane_word;
    endcase
  end

  // Literals of byte size come from the instruction; wider ones arrive via pc-relative loads above
  logic [31:0] next_literal;
  assign next_literal = (i_lit_kind == CCS_LIT_LOGIC) ? {24'h000000, i_literal} :
    {{24{i_literal[7]}}, i_literal};

  // Memory bit logic: and, or, xor, test on the loaded operand
  logic [31:0] next_bit;
  always_comb
  begin
    unique case (i_bit_op)
      2'b00: next_bit = i_bit_operand & i_bit_mask;
      2'b01: next_bit = i_bit_operand | i_bit_mask;
      2'b10: next_bit = i_bit_operand ^ i_bit_mask;
      default: next_bit = i_bit_operand;
    endcase
  end

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  logic [31:0] next_rdata;
  always_comb
  begin
    unique case (i_creg.sel)
      CCS_R_SW: next_rdata = processor_status_word & SW_IMPL_MASK;
      CCS_R_SSW: next_rdata = saved_status_word;
      CCS_R_SPC: next_rdata = saved_program_counter;
      CCS_R_GBP: next_rdata = global_base_pointer;
      CCS_R_VBP: next_rdata = vector_base_pointer;
      default: next_rdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge i_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      o_creg_rdata <= 32'h00000000;
      o_priv_fault <= 1'b0;
      o_load_data <= 32'h00000000;
      o_address_error <= 1'b0;
      o_literal <= 32'h00000000;
      o_bit_result <= 32'h00000000;
    end
    else
    begin
      o_creg_rdata <= (i_creg.valid && creg_allowed) ? next_rdata : 32'h00000000;
      o_priv_fault <= creg_fault;
      o_load_data <= next_load;
      o_address_error <= i_mem.valid && misaligned;
      o_literal <= next_literal;
      o_bit_result <= next_bit;
    end
  end

  assign o_pc = pc;
  assign o_pc_read = pc + PC_AHEAD;
  assign o_little_endian = little_endian;
  assign o_interrupt_mask_level = processor_status_word[SW_MASK_HI:SW_MASK_LO];
  assign o_cond = processor_status_word[SW_COND];
  assign o_clip = processor_status_word[SW_CLIP];
  assign o_privilege_level_bit = processor_status_word[SW_PRIV];
  assign o_bank_select_bit = processor_status_word[SW_BANK];
  assign o_exception_mute_bit = processor_status_word[SW_MUTE];
  assign o_global_base_pointer = global_base_pointer;
  assign o_vector_base_pointer = vector_base_pointer;

endmodule

// File: ccs_mem_model.sv
// Behavioural memory system on the processor data bus.
// Assumes the core samples read data in the cycle of its request.
module ccs_mem_model
(
  input wire logic i_clk,
  input wire logic i_valid,
  input wire logic [31:0] i_addr,
  output logic [31:0] o_rdata
);
  // ----------------------------------------
  // Two fixed words, then inverted hold
  // ----------------------------------------
  logic [31:0] last;
  logic [31:0] word;
  assign word = i_addr[2] ? 32'h7f8011fe : 32'h8a7bf01c;
  // Idle bus shows the inverse so a stale value is never mistaken for data
  assign o_rdata = i_valid ? word : ~last;
  always_ff @(posedge i_clk)
  begin
    if (i_valid)
    begin
      last <= word;
    end
  end
endmodule

// File: ccs_core_state_chk.sv
// Timing checks on the ports of the control-state block.
// Assumes one clock domain and the active-low reset port.
module ccs_core_state_chk
  import ccs_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire ccs_creg_s i_creg,
  input wire ccs_flag_s i_flags,
  input wire logic i_exception,
  input wire logic i_return,
  input wire logic i_advance,
  input wire ccs_br_e i_branch,
  input wire logic i_branch_taken,
  input wire logic [31:0] i_branch_target,
  input wire ccs_mem_s i_mem,
  input wire logic [31:0] o_creg_rdata,
  input wire logic o_priv_fault,
  input wire logic [31:0] o_pc,
  input wire logic [31:0] o_pc_read,
  input wire logic [31:0] o_load_data,
  input wire logic o_address_error,
  input wire logic [3:0] o_interrupt_mask_level,
  input wire logic o_cond,
  input wire logic o_privilege_level_bit,
  input wire logic o_bank_select_bit,
  input wire logic o_exception_mute_bit,
  input wire logic [31:0] o_vector_base_pointer
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  wire misaligned_req = (i_mem.size == CCS_SZ_WORD && i_mem.addr[0]) ||
    (i_mem.size == CCS_SZ_LONG && i_mem.addr[1:0] != 2'h0);
  sequence s_slot;
    i_advance && i_branch == CCS_BR_DELAYED && i_branch_taken && !i_exception && !i_return
    ##1 i_advance && !i_exception && !i_return;
  endsequence
  property p_rsv;
    i_creg.valid && !i_creg.write && i_creg.sel == CCS_R_SW |=> o_creg_rdata[11:10] == 0 && o_creg_rdata[3:2] == 0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved status bits read nonzero");
  property p_mask;
    i_exception |=> o_interrupt_mask_level == $past(o_interrupt_mask_level);
  endproperty
  a_mask: assert property (p_mask) else $error("mask level changed on exception");
  property p_exbits;
    i_exception |=> o_privilege_level_bit && o_bank_select_bit && o_exception_mute_bit;
  endproperty
  a_exbits: assert property (p_exbits) else $error("exception mode bits not set");
  property p_align;
    i_mem.valid |=> o_address_error == $past(misaligned_req);
  endproperty
  a_align: assert property (p_align) else $error("address error wrong");
  property p_sext;
    i_mem.valid && i_mem.size == CCS_SZ_BYTE |=> o_load_data[31:8] == {24{o_load_data[7]}};
  endproperty
  a_sext: assert property (p_sext) else $error("byte load not sign extended");
  property p_pcr;
    o_pc_read == o_pc + PC_AHEAD;
  endproperty
  a_pcr: assert property (p_pcr) else $error("pc read not four ahead");
  property p_cond;
    !i_flags.cond_we && !i_exception && !i_return && !(i_creg.valid && i_creg.write && i_creg.sel == CCS_R_SW)
    |=> $stable(o_cond);
  endproperty
  a_cond: assert property (p_cond) else $error("condition flag changed");
  property p_slot;
    s_slot |=> o_pc == $past(i_branch_target, 2);
  endproperty
  a_slot: assert property (p_slot) else $error("delayed branch target missed");
  property p_priv;
    !o_privilege_level_bit && i_creg.valid && i_creg.sel == CCS_R_VBP && !i_exception
    |=> o_priv_fault && $stable(o_vector_base_pointer);
  endproperty
  a_priv: assert property (p_priv) else $error("user access to vector base not refused");
endmodule

bind ccs_core_state ccs_core_state_chk i_ccs_core_state_chk (.i_clk, .i_rst_b, .i_creg, .i_flags,
  .i_exception, .i_return, .i_advance, .i_branch, .i_branch_taken, .i_branch_target, .i_mem,
  .o_creg_rdata, .o_priv_fault, .o_pc, .o_pc_read, .o_load_data, .o_address_error,
  .o_interrupt_mask_level, .o_cond, .o_privilege_level_bit, .o_bank_select_bit,
  .o_exception_mute_bit, .o_vector_base_pointer);

// File: tb_top.sv
// Self-checking bench for the control-state block.
// Assumes the memory model answers in the request cycle.
module tb_top
  import ccs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic i_clk = 0, i_rst_b = 0, pin = 1, exc = 0, ret = 0, adv = 0, btk = 0, mv = 0;
  ccs_creg_s creg = '0;
  ccs_flag_s flg = '0;
  ccs_br_e br = CCS_BR_NONE;
  ccs_size_e msz = CCS_SZ_BYTE;
  ccs_lit_e lk = CCS_LIT_MOVE;
  ccs_mem_s mem;
  logic [31:0] btgt = '0, ma = '0, mrd, crd, pc, pcr, ld, lo, bres, gbp, vbp;
  logic [1:0] bsel = '0;
  logic pf, ae, le, cond, clip, pl, bk, mu;
  logic [3:0] ml;
  int bad_count = 0, cmp_count = 0, cyc = 0;
  typedef struct {ccs_size_e sz; logic [31:0] a; logic [31:0] d; logic e;} ccs_row_s;
  ccs_row_s rows[11] = '{'{CCS_SZ_BYTE, 32'h100, 32'h1c, 1'b0}, '{CCS_SZ_BYTE, 32'h101, 32'hfffffff0, 1'b0},
    '{CCS_SZ_BYTE, 32'h103, 32'hffffff8a, 1'b0}, '{CCS_SZ_BYTE, 32'h106, 32'hffffff80, 1'b0},
    '{CCS_SZ_WORD, 32'h100, 32'hfffff01c, 1'b0}, '{CCS_SZ_WORD, 32'h102, 32'hffff8a7b, 1'b0},
    '{CCS_SZ_WORD, 32'h106, 32'h7f80, 1'b0}, '{CCS_SZ_WORD, 32'h101, 32'h0, 1'b1},
    '{CCS_SZ_LONG, 32'h104, 32'h7f8011fe, 1'b0}, '{CCS_SZ_LONG, 32'h102, 32'h0, 1'b1},
    '{CCS_SZ_LONG, 32'h101, 32'h0, 1'b1}};
  logic [31:0] lexp[4] = '{32'hffffff85, 32'hffffff85, 32'hffffff85, 32'h85};
  logic [31:0] bexp[4] = '{32'h000f00f0, 32'h0fff0fff, 32'h0ff00f0f, 32'h0f0f00ff};
  assign mem = {mv, msz, ma, mrd};
  ccs_mem_model i_ccs_mem_model (.i_clk(i_clk), .i_valid(mv), .i_addr(ma), .o_rdata(mrd));
  ccs_core_state i_ccs_core_state (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_endian_select_pin(pin),
    .i_creg(creg), .i_flags(flg), .i_exception(exc), .i_return(ret), .i_advance(adv), .i_branch(br),
    .i_branch_taken(btk), .i_branch_target(btgt), .i_mem(mem), .i_literal(8'h85), .i_lit_kind(lk),
    .i_bit_operand(32'h0f0f00ff), .i_bit_mask(32'h00ff0ff0), .i_bit_op(bsel), .o_creg_rdata(crd),
    .o_priv_fault(pf), .o_pc(pc), .o_pc_read(pcr), .o_load_data(ld), .o_address_error(ae), .o_literal(lo),
    .o_bit_result(bres), .o_little_endian(le), .o_interrupt_mask_level(ml), .o_cond(cond), .o_clip(clip),
    .o_privilege_level_bit(pl), .o_bank_select_bit(bk), .o_exception_mute_bit(mu),
    .o_global_base_pointer(gbp), .o_vector_base_pointer(vbp));
  // ----------------------------------------
  // Clock, timeout and shared tasks
  // ----------------------------------------
  initial
  begin
    forever #12.5 i_clk = ~i_clk;
  end
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      bad_count++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e)
    begin
      $display("mismatch %s expected %h seen %h", n, e, s);
      bad_count++;
    end
  endtask
  // Inputs change 2 ns after the edge; each shared task drops its request an edge before the next
  task automatic go();
    @(posedge i_clk);
    #2;
  endtask
  task automatic cr(input logic w, input ccs_reg_e s, input logic [31:0] d);
    go();
    creg = {1'b1, w, s, d};
    go();
    creg = '0;
  endtask
  task automatic fl(input ccs_flag_s f);
    go();
    flg = f;
    go();
    flg = '0;
  endtask
  task automatic step(input ccs_br_e b, input logic t, input logic [31:0] g);
    go();
    {adv, br, btk, btgt} = {1'b1, b, t, g};
    go();
    {adv, br, btk} = {1'b0, CCS_BR_NONE, 1'b0};
  endtask
  task automatic evt(input logic e, input logic r);
    go();
    {exc, ret} = {e, r};
    go();
    {exc, ret} = 2'h0;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    // Strap held through reset and beyond the sync flops
    repeat (2) go();
    i_rst_b = 1;
    repeat (3) go();
    pin = 0;
    chk("pc", PC_RESET, pc);
    chk("pc_read", PC_RESET + PC_AHEAD, pcr);
    chk("vbp", VBP_RESET, vbp);
    chk("mask", 32'hf, {28'h0, ml});
    cr(1'b0, CCS_R_SW, 32'h0);
    chk("sw", SW_RESET, crd);
    fl(6'h2f);
    cr(1'b0, CCS_R_SW, 32'h0);
    chk("sw_flags", 32'h700003f0, crd);
    cr(1'b1, CCS_R_SW, 32'hffffffff);
    cr(1'b0, CCS_R_SW, 32'h0);
    chk("sw_rsv", SW_IMPL_MASK, crd);
    chk("clip", 32'h1, {31'h0, clip});
    step(CCS_BR_NONE, 1'b0, 32'h0);
    step(CCS_BR_NONE, 1'b0, 32'h0);
    cr(1'b1, CCS_R_SW, 32'h51);
    chk("sw_out", 32'h15, {26'h0, ml, pl, cond});
    cr(1'b0, CCS_R_SW, 32'h0);
    chk("fault", 32'h1, {31'h0, pf});
    chk("refused", 32'h0, crd);
    evt(1'b1, 1'b0);
    chk("mask_kept", 32'h5, {28'h0, ml});
    chk("ex_bits", 32'h7, {29'h0, pl, bk, mu});
    cr(1'b0, CCS_R_SSW, 32'h0);
    chk("ssw", 32'h51, crd);
    cr(1'b0, CCS_R_SPC, 32'h0);
    chk("spc", PC_RESET + 32'h4, crd);
    evt(1'b0, 1'b1);
    chk("ret_pc", PC_RESET + 32'h4, pc);
    cr(1'b1, CCS_R_GBP, 32'h12345678);
    cr(1'b0, CCS_R_GBP, 32'h0);
    chk("gbp", 32'h12345678, crd);
    chk("gbp_out", 32'h12345678, gbp);
    cr(1'b1, CCS_R_VBP, 32'hdead);
    chk("vbp_fault", 32'h1, {31'h0, pf});
    chk("vbp_kept", 32'h0, vbp);
    fl(6'h20);
    chk("cond_user", 32'h0, {31'h0, cond});
    step(CCS_BR_DELAYED, 1'b1, 32'h200);
    chk("slot_pc", PC_RESET + 32'h6, pc);
    step(CCS_BR_NONE, 1'b0, 32'h0);
    chk("br_pc", 32'h200, pc);
    step(CCS_BR_NORMAL, 1'b1, 32'h300);
    chk("nbr_pc", 32'h300, pc);
    chk("endian", 32'h1, {31'h0, le});
    foreach (rows[k])
    begin
      go();
      {mv, msz, ma} = {1'b1, rows[k].sz, rows[k].a};
      go();
      mv = 0;
      chk("addr_err", {31'h0, rows[k].e}, {31'h0, ae});
      if (!rows[k].e)
        chk("load", rows[k].d, ld);
    end
    for (int k = 0; k < 4; k++)
    begin
      go();
      lk = ccs_lit_e'(k[1:0]);
      bsel = k[1:0];
      go();
      chk("literal", lexp[k], lo);
      chk("bit_logic", bexp[k], bres);
    end
    // Delay slot retiring in the very next cycle
    go();
    {adv, br, btk, btgt} = {1'b1, CCS_BR_DELAYED, 1'b1, 32'h400};
    go();
    {br, btk} = {CCS_BR_NONE, 1'b0};
    chk("b2b_slot", 32'h302, pc);
    go();
    adv = 0;
    chk("b2b_pc", 32'h400, pc);
    // Second reset with the strap low: big-endian from then on
    go();
    i_rst_b = 0;
    repeat (2) go();
    i_rst_b = 1;
    repeat (3) go();
    pin = 1;
    chk("reset_pc", PC_RESET, pc);
    chk("reset_mask", 32'hf, {28'h0, ml});
    chk("endian_big", 32'h0, {31'h0, le});
    go();
    {mv, msz, ma} = {1'b1, CCS_SZ_WORD, 32'h100};
    go();
    {msz, ma} = {CCS_SZ_LONG, 32'h104};
    chk("load_big_word", 32'h00001cf0, ld);
    go();
    mv = 0;
    chk("load_big_long", 32'hfe11807f, ld);
    print_verdict();
  end
endmodule
